// ### pkg/spo_pkg.sv
// Shared constants and types for the setpoint output block.
// Assumes a single system clock; values and setpoints are binary signed counts, hysteresis and delays unsigned.
package spo_pkg;

    // ----------------------------------------------------------------
    // Widths and channel count
    // ----------------------------------------------------------------
    localparam int NSP       = 2;
    localparam int SP2_IDX   = 1;
    localparam int VAL_W     = 18;
    localparam int EXT_W     = 20;
    localparam int HYS_W     = 16;
    localparam int ON_DLY_W  = 10;
    localparam int OFF_DLY_W = 13;
    localparam int CNT_W     = 13;

    // ----------------------------------------------------------------
    // Value ranges
    // ----------------------------------------------------------------
    localparam logic signed [VAL_W-1:0] VAL_MIN     = -18'sd19999;
    localparam logic signed [VAL_W-1:0] VAL_MAX     = 18'sd99999;
    localparam logic [HYS_W-1:0]        HYS_MIN     = 16'd1;
    localparam logic [HYS_W-1:0]        HYS_MAX     = 16'd59999;
    localparam logic [ON_DLY_W-1:0]     ON_DLY_MAX  = 10'd999;
    localparam logic [OFF_DLY_W-1:0]    OFF_DLY_MAX = 13'd5999;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ      = 10_000_000;
    localparam int TICK_S      = 1;
    localparam int TICK_CYCLES = TICK_S * CLK_HZ;
    localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 13'h0001;

    // ----------------------------------------------------------------
    // Modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_HIGH_BAL   = 2'h0,
        ACT_LOW_BAL    = 2'h1,
        ACT_HIGH_UNBAL = 2'h2,
        ACT_LOW_UNBAL  = 2'h3
    } spo_act_e;

    typedef enum logic [1:0] {
        RST_AUTO            = 2'h0,
        RST_LATCH_IMMEDIATE = 2'h1,
        RST_LATCH_DEFERRED  = 2'h2
    } spo_rst_e;

    // Gray order along off -> wait -> on -> wait -> off
    typedef enum logic [1:0] {
        ST_OFF      = 2'h0,
        ST_ON_WAIT  = 2'h1,
        ST_ON       = 2'h3,
        ST_OFF_WAIT = 2'h2
    } spo_st_e;

    localparam logic COLOUR_RST = 1'b0;

endpackage : spo_pkg

// ### pkg/spo_trip_if.sv
// Carrier between the controller and one trip comparator.
// Assumes both ends sit in the same clock domain.
interface spo_trip_if;
    import spo_pkg::*;

    logic signed [VAL_W-1:0] value;
    logic signed [VAL_W-1:0] setpoint;
    logic [HYS_W-1:0]        hyst;
    spo_act_e                action;
    logic                    on_cond;
    logic                    off_cond;
    logic                    at_or_above_sp;

    modport trip (
        input  value, setpoint, hyst, action,
        output on_cond, off_cond, at_or_above_sp
    );

    modport ctrl (
        output value, setpoint, hyst, action,
        input  on_cond, off_cond, at_or_above_sp
    );

endinterface : spo_trip_if

// ### hdl/spo_tick.sv
// One-second timing tick from the system clock.
// Assumes mclk_i runs at the rate the cycle count was derived for.
module spo_tick #(
    parameter int TICK_CYCLES = spo_pkg::TICK_CYCLES
) (
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    output logic      tick_o
);
    import spo_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] LAST = TW'(TICK_CYCLES - 1);

    logic [TW-1:0] div_r;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            div_r  <= '0;
            tick_o <= 1'b0;
        end else if (div_r >= LAST) begin
            div_r  <= '0;
            tick_o <= 1'b1;
        end else begin
            div_r  <= div_r + TW'(1);
            tick_o <= 1'b0;
        end
    end

endmodule // spo_tick

// ### hdl/spo_trip.sv
// Trip comparator: switch points from setpoint, hysteresis and action.
// Assumes inputs are stable within a cycle; purely combinational.
module spo_trip (
    spo_trip_if.trip tif
);
    import spo_pkg::*;

    function automatic logic signed [VAL_W-1:0] clamp_val(
        input logic signed [VAL_W-1:0] v
    );
        if (v < VAL_MIN) return VAL_MIN;
        else if (v > VAL_MAX) return VAL_MAX;
        else return v;
    endfunction

    function automatic logic [HYS_W-1:0] clamp_hys(input logic [HYS_W-1:0] h);
        if (h < HYS_MIN) return HYS_MIN;
        else if (h > HYS_MAX) return HYS_MAX;
        else return h;
    endfunction

    logic signed [EXT_W-1:0] val_x;
    logic signed [EXT_W-1:0] sp_x;
    logic signed [EXT_W-1:0] h_x;
    logic signed [EXT_W-1:0] half_x;
    logic signed [EXT_W-1:0] up_bal;
    logic signed [EXT_W-1:0] dn_bal;

    assign val_x  = EXT_W'(tif.value);
    assign sp_x   = EXT_W'(clamp_val(tif.setpoint));
    assign h_x    = signed'(EXT_W'(clamp_hys(tif.hyst)));
    assign half_x = h_x >>> 1;
    assign up_bal = sp_x + half_x;
    assign dn_bal = sp_x - half_x;

    assign tif.at_or_above_sp = (val_x >= sp_x);

    always_comb begin
        tif.on_cond  = 1'b0;
        tif.off_cond = 1'b0;
        case (tif.action)
            ACT_HIGH_BAL: begin
                tif.on_cond  = (val_x >= up_bal);
                tif.off_cond = (val_x <= dn_bal);
            end
            ACT_LOW_BAL: begin
                tif.on_cond  = (val_x <= dn_bal);
                tif.off_cond = (val_x >= up_bal);
            end
            ACT_HIGH_UNBAL: begin
                tif.on_cond  = (val_x >= sp_x);
                tif.off_cond = (val_x <= sp_x - h_x);
            end
            default: begin
                tif.on_cond  = (val_x <= sp_x);
                tif.off_cond = (val_x >= sp_x + h_x);
            end
        endcase
    end

endmodule // spo_trip

// ### hdl/spo_top.sv
// Setpoint output controller for two process-meter setpoints.
// Assumes all inputs synchronous to mclk_i; reset pulses one cycle wide.
//
// Function
// - A disabled second setpoint is held inactive.
// - Each output offers high or low acting with balanced or unbalanced hysteresis.
// - Setpoints span -19999 to 99999 in display units.
// - Hysteresis spans 1 to 59999 and sets the switch points.
// - Unbalanced bands sit below the setpoint if high acting, above if low.
// - Turn-on waits the on delay of up to 999 s; zero means no wait.
// - Turn-off waits the off delay of up to 5999 s; zero means no wait.
// - Automatic mode turns the output off at the off point.
// - In automatic mode a manual reset clears at once until re-triggered.
// - Immediate latch holds on until a manual, serial or power reset.
// - Deferred latch remembers a reset and clears at the off point.
// - A restored latched output stays off if the value is below setpoint.
// - A pending deferred reset is dropped across a power cycle.
// - A qualified display reset also resets the output when enabled.
// - Standby keeps the output disabled until the trigger is first crossed.
// - Colour change toggles the backlight when exactly one output changes in a cycle; two changes in one cycle cancel.
module spo_top #(
    parameter int TICK_CYCLES = spo_pkg::TICK_CYCLES
) (
    input  wire logic                           mclk_i,
    input  wire logic                           reset_n_i,
    input  wire logic signed [spo_pkg::VAL_W-1:0] value_i,
    input  wire logic signed [spo_pkg::VAL_W-1:0] sp_value_i   [spo_pkg::NSP],
    input  wire logic [spo_pkg::HYS_W-1:0]      hyst_i         [spo_pkg::NSP],
    input  wire spo_pkg::spo_act_e              action_i       [spo_pkg::NSP],
    input  wire spo_pkg::spo_rst_e              rst_mode_i     [spo_pkg::NSP],
    input  wire logic [spo_pkg::ON_DLY_W-1:0]   on_dly_i       [spo_pkg::NSP],
    input  wire logic [spo_pkg::OFF_DLY_W-1:0]  off_dly_i      [spo_pkg::NSP],
    input  wire logic [spo_pkg::NSP-1:0]        rst_w_disp_en_i,
    input  wire logic [spo_pkg::NSP-1:0]        standby_en_i,
    input  wire logic [spo_pkg::NSP-1:0]        prior_latched_i,
    input  wire logic                           sp2_enable_i,
    input  wire logic                           colour_chg_en_i,
    input  wire logic                           backlit_i,
    input  wire logic                           base_colour_i,
    input  wire logic                           manual_rst_i,
    input  wire logic                           serial_rst_i,
    input  wire logic                           display_rst_i,
    input  wire logic                           display_reset_assignment_i,
    input  wire logic                           input_shown_i,
    output logic [spo_pkg::NSP-1:0]             sp_out_o,
    output logic [spo_pkg::NSP-1:0]             rst_pending_o,
    output logic                                colour_o
);
    import spo_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic drives_on(input spo_st_e s);
        return (s == ST_ON) || (s == ST_OFF_WAIT);
    endfunction

    function automatic logic cnt_done(input logic [CNT_W-1:0] c,
                                      input logic [CNT_W-1:0] lim);
        return c >= lim;
    endfunction

    // ----------------------------------------------------------------
    // Tick and trip comparators
    // ----------------------------------------------------------------
    logic              tick;
    logic [NSP-1:0]    on_c;
    logic [NSP-1:0]    off_c;
    logic [NSP-1:0]    ge_sp;
    logic [NSP-1:0]    en;
    logic [NSP-1:0]    clr_now;
    logic [NSP-1:0]    defer_req;
    logic              disp_rst_q;
    logic [CNT_W-1:0]  on_lim  [NSP];
    logic [CNT_W-1:0]  off_lim [NSP];
    logic [NSP-1:0]    block_r;
    logic [NSP-1:0]    standby_r;
    logic [NSP-1:0]    pend_r;

    spo_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .tick_o    (tick)
    );

    spo_trip_if trip_if [NSP] ();

    for (genvar g = 0; g < NSP; g++) begin : g_ch
        assign trip_if[g].value    = value_i;
        assign trip_if[g].setpoint = sp_value_i[g];
        assign trip_if[g].hyst     = hyst_i[g];
        assign trip_if[g].action   = action_i[g];
        assign on_c[g]             = trip_if[g].on_cond;
        assign off_c[g]            = trip_if[g].off_cond;
        assign ge_sp[g]            = trip_if[g].at_or_above_sp;

        spo_trip u_trip (
            .tif (trip_if[g])
        );

        // Delay limits clamped to their ranges
        assign on_lim[g]  = (on_dly_i[g] > ON_DLY_MAX) ? CNT_W'(ON_DLY_MAX)
                                                        : CNT_W'(on_dly_i[g]);
        assign off_lim[g] = (off_dly_i[g] > OFF_DLY_MAX) ? CNT_W'(OFF_DLY_MAX)
                                                          : CNT_W'(off_dly_i[g]);
    end

    // ----------------------------------------------------------------
    // Reset source qualification
    // ----------------------------------------------------------------
    assign disp_rst_q = display_rst_i && display_reset_assignment_i && input_shown_i;

    always_comb begin
        for (int i = 0; i < NSP; i++) begin
            en[i]        = (i == SP2_IDX) ? sp2_enable_i : 1'b1;
            clr_now[i]   = 1'b0;
            defer_req[i] = 1'b0;
            case (rst_mode_i[i])
                RST_AUTO: begin
                    clr_now[i] = manual_rst_i || (disp_rst_q && rst_w_disp_en_i[i]);
                end
                RST_LATCH_IMMEDIATE: begin
                    clr_now[i] = manual_rst_i || serial_rst_i
                              || (disp_rst_q && rst_w_disp_en_i[i]);
                end
                RST_LATCH_DEFERRED: begin
                    defer_req[i] = manual_rst_i || serial_rst_i
                                || (disp_rst_q && rst_w_disp_en_i[i]);
                end
                default: begin
                    clr_now[i] = manual_rst_i;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power-up marker
    // ----------------------------------------------------------------
    logic init_r;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output state machines and delay counters
    // ----------------------------------------------------------------
    spo_st_e          st_r  [NSP];
    logic [CNT_W-1:0] cnt_r [NSP];

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NSP; i++) begin
            if (!reset_n_i) begin
                st_r[i]  <= ST_OFF;
                cnt_r[i] <= CNT_ZERO;
            end else if (init_r) begin
                cnt_r[i] <= CNT_ZERO;
                if (prior_latched_i[i] && en[i] && ge_sp[i]
                    && (rst_mode_i[i] != RST_AUTO)) begin
                    st_r[i] <= ST_ON;
                end else begin
                    st_r[i] <= ST_OFF;
                end
            end else if (!en[i]) begin
                st_r[i]  <= ST_OFF;
                cnt_r[i] <= CNT_ZERO;
            end else if (clr_now[i]) begin
                st_r[i]  <= ST_OFF;
                cnt_r[i] <= CNT_ZERO;
            end else begin
                case (st_r[i])
                    ST_OFF: begin
                        cnt_r[i] <= CNT_ZERO;
                        if (on_c[i] && !block_r[i] && !standby_r[i]) begin
                            st_r[i] <= ST_ON_WAIT;
                        end
                    end
                    ST_ON_WAIT: begin
                        if (!on_c[i]) begin
                            st_r[i]  <= ST_OFF;
                            cnt_r[i] <= CNT_ZERO;
                        end else if (cnt_done(cnt_r[i], on_lim[i])) begin
                            st_r[i]  <= ST_ON;
                            cnt_r[i] <= CNT_ZERO;
                        end else if (tick) begin
                            cnt_r[i] <= cnt_r[i] + CNT_ONE;
                        end
                    end
                    ST_ON: begin
                        cnt_r[i] <= CNT_ZERO;
                        if (off_c[i] && (rst_mode_i[i] == RST_AUTO)) begin
                            st_r[i] <= ST_OFF_WAIT;
                        end else if (off_c[i] && pend_r[i]
                                     && (rst_mode_i[i] == RST_LATCH_DEFERRED)) begin
                            st_r[i] <= ST_OFF_WAIT;
                        end
                    end
                    default: begin
                        if (!off_c[i]) begin
                            st_r[i]  <= ST_ON;
                            cnt_r[i] <= CNT_ZERO;
                        end else if (cnt_done(cnt_r[i], off_lim[i])) begin
                            st_r[i]  <= ST_OFF;
                            cnt_r[i] <= CNT_ZERO;
                        end else if (tick) begin
                            cnt_r[i] <= cnt_r[i] + CNT_ONE;
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Re-trigger block, standby and deferred request
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NSP; i++) begin
            if (!reset_n_i) begin
                block_r[i] <= 1'b0;
            end else if (clr_now[i] && (st_r[i] != ST_OFF)) begin
                block_r[i] <= 1'b1;
            end else if (!on_c[i]) begin
                block_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NSP; i++) begin
            if (!reset_n_i) begin
                standby_r[i] <= 1'b1;
            end else if (init_r) begin
                standby_r[i] <= standby_en_i[i];
            end else if (!on_c[i]) begin
                standby_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NSP; i++) begin
            if (!reset_n_i) begin
                pend_r[i] <= 1'b0;
            end else if (defer_req[i] && drives_on(st_r[i])) begin
                pend_r[i] <= 1'b1;
            end else if ((st_r[i] == ST_OFF) || (rst_mode_i[i] != RST_LATCH_DEFERRED)) begin
                pend_r[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Output pins and backlight colour
    // ----------------------------------------------------------------
    logic [NSP-1:0] out_now;
    logic [NSP-1:0] out_r;
    logic           colour_r;

    always_comb begin
        for (int i = 0; i < NSP; i++) begin
            out_now[i] = drives_on(st_r[i]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            out_r <= '0;
        end else begin
            out_r <= out_now;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            colour_r <= COLOUR_RST;
        end else if (init_r) begin
            colour_r <= base_colour_i;
        end else if (colour_chg_en_i && backlit_i) begin
            colour_r <= colour_r ^ (^(out_now ^ out_r));
        end
    end

    assign sp_out_o      = out_r;
    assign rst_pending_o = pend_r;
    assign colour_o      = colour_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sp2_off_a: assert property (!sp2_enable_i && !init_r |=> ##1 !sp_out_o[SP2_IDX])
        else $error("disabled second setpoint output active");

    on_delay_a: assert property (st_r[0] == ST_ON_WAIT ##1 st_r[0] == ST_ON
                                 |-> $past(cnt_r[0]) >= $past(on_lim[0]))
        else $error("output turned on before on delay");

    off_delay_a: assert property (st_r[0] == ST_OFF_WAIT && !clr_now[0] && en[0]
                                  && cnt_r[0] < off_lim[0] |=> st_r[0] != ST_OFF)
        else $error("output turned off before off delay");

    auto_off_a: assert property (rst_mode_i[0] == RST_AUTO && st_r[0] == ST_ON && off_c[0]
                                 && !clr_now[0] && !init_r |=> ##1 sp_out_o[0])
        else $error("auto off path skipped off wait");

    manual_clr_a: assert property (rst_mode_i[0] == RST_AUTO && manual_rst_i && !init_r
                                   |=> st_r[0] == ST_OFF ##1 !sp_out_o[0])
        else $error("manual reset did not clear output");

    latch_hold_a: assert property (rst_mode_i[0] == RST_LATCH_IMMEDIATE && st_r[0] == ST_ON
                                   && !clr_now[0] && !init_r |=> st_r[0] == ST_ON)
        else $error("latched output dropped without reset");

    defer_pend_a: assert property (rst_mode_i[0] == RST_LATCH_DEFERRED && st_r[0] == ST_ON
                                   && defer_req[0] && !off_c[0] && !init_r
                                   |=> pend_r[0] && st_r[0] == ST_ON)
        else $error("deferred reset not remembered");

    restore_a: assert property (init_r && !ge_sp[0] |=> st_r[0] == ST_OFF ##1 !sp_out_o[0])
        else $error("restored output on below setpoint");

    disp_rst_a: assert property (disp_rst_q && rst_w_disp_en_i[0] && !init_r
                                 && rst_mode_i[0] == RST_AUTO |=> st_r[0] == ST_OFF)
        else $error("display reset did not reset output");

    standby_a: assert property (standby_r[0] && st_r[0] == ST_OFF && !init_r
                                |=> st_r[0] == ST_OFF)
        else $error("output left off during standby");

    colour_tog_a: assert property (colour_chg_en_i && backlit_i && !init_r
                                   && (out_now[0] != out_r[0]) && (out_now[1] == out_r[1])
                                   |=> colour_r != $past(colour_r))
        else $error("colour did not toggle on output change");

    restart_a: assert property (st_r[0] == ST_ON_WAIT && !on_c[0] && !init_r
                                |=> st_r[0] == ST_OFF && cnt_r[0] == CNT_ZERO)
        else $error("on delay not restarted");

    ch0_on_c: cover property (st_r[0] == ST_ON_WAIT ##1 st_r[0] == ST_ON);
    defer_clr_c: cover property (pend_r[0] ##[1:20] st_r[0] == ST_OFF);
    colour_c: cover property (colour_chg_en_i && backlit_i ##1 $changed(colour_r));

endmodule // spo_top

// ### bench/spo_panel.sv
// Far-side model: front panel key, user input and serial reset sources.
// Assumes the bench calls press() and the block samples on rising edges.
module spo_panel (
    input  wire logic mclk_i,
    output logic      manual_rst_o,
    output logic      serial_rst_o,
    output logic      display_rst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        manual_rst_o = 1'b0;
        serial_rst_o = 1'b0;
        display_rst_o = 1'b0;
    end
    // ----------------------------------------------------------------
    // One-cycle reset pulse between falling edges
    // ----------------------------------------------------------------
    task press(input int k);
        @(negedge mclk_i);
        manual_rst_o = (k == 0);
        serial_rst_o = (k == 1);
        display_rst_o = (k == 2);
        @(negedge mclk_i);
        manual_rst_o = 1'b0;
        serial_rst_o = 1'b0;
        display_rst_o = 1'b0;
    endtask
endmodule // spo_panel

// ### bench/setpoint_output_control_tb_top.sv
// Bench top for the setpoint output block.
// Assumes spo_pkg, spo_top and spo_panel are compiled first.
module setpoint_output_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import spo_pkg::*;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic signed [VAL_W-1:0] val = 18'h00000;
    logic signed [VAL_W-1:0] sp [NSP] = '{18'h00064, 18'h00064};
    logic [HYS_W-1:0]        hy [NSP] = '{16'h000a, 16'h000a};
    spo_act_e                act [NSP] = '{ACT_HIGH_BAL, ACT_HIGH_BAL};
    spo_rst_e                md [NSP] = '{RST_AUTO, RST_AUTO};
    logic [ON_DLY_W-1:0]     ond [NSP] = '{10'h000, 10'h000};
    logic [OFF_DLY_W-1:0]    ofd [NSP] = '{13'h0000, 13'h0000};
    logic [NSP-1:0]          out, pend;
    logic [NSP-1:0]          rwd = 2'b00, sby = 2'b00, prl = 2'b00;
    logic                    sp2 = 1'b0;
    logic signed [VAL_W-1:0] pv = 18'h00000;
    logic                    col, mrst, srst, drst;
    int                      errors = 0, checks = 0, cc = 0;

    always #50 clk = ~clk;

    spo_top #(.TICK_CYCLES(10)) dut (.mclk_i(clk), .reset_n_i(rst_n), .value_i(val),
        .sp_value_i(sp), .hyst_i(hy), .action_i(act), .rst_mode_i(md), .on_dly_i(ond),
        .off_dly_i(ofd), .rst_w_disp_en_i(rwd), .standby_en_i(sby),
        .prior_latched_i(prl), .sp2_enable_i(sp2), .colour_chg_en_i(1'b1),
        .backlit_i(1'b1), .base_colour_i(1'b0), .manual_rst_i(mrst), .serial_rst_i(srst),
        .display_rst_i(drst), .display_reset_assignment_i(1'b1), .input_shown_i(1'b1),
        .sp_out_o(out), .rst_pending_o(pend), .colour_o(col));
    spo_panel u (.mclk_i(clk), .manual_rst_o(mrst), .serial_rst_o(srst), .display_rst_o(drst));

    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input string s, input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task pwr(input spo_rst_e m, input spo_act_e a);
        rst_n = 1'b0;
        val = pv;
        md = '{m, m};
        act = '{a, a};
        cyc(16);
        rst_n = 1'b1;
        cyc(2);
    endtask
    task setv(input int v, input int n);
        val = v[VAL_W-1:0];
        cyc(n);
    endtask

    task t_auto;
        pwr(RST_AUTO, ACT_HIGH_BAL);
        setv(105, 5);
        chk("sp_out", out, 2'b01);
        u.press(0);
        cyc(3);
        chk("sp_out", out, 2'b00);
        setv(90, 5);
        setv(105, 5);
        chk("sp_out", out, 2'b01);
        setv(94, 5);
        chk("sp_out", out, 2'b00);
        $display("test auto done");
    endtask
    task t_unbal;
        pwr(RST_AUTO, ACT_HIGH_UNBAL);
        setv(100, 5);
        chk("sp_out0", out[0], 1'b1);
        setv(95, 5);
        chk("sp_out0", out[0], 1'b1);
        setv(90, 5);
        chk("sp_out0", out[0], 1'b0);
        $display("test unbalanced done");
    endtask
    task t_imm;
        pwr(RST_LATCH_IMMEDIATE, ACT_HIGH_BAL);
        setv(105, 5);
        setv(90, 5);
        chk("sp_out0", out[0], 1'b1);
        u.press(1);
        cyc(3);
        chk("sp_out0", out[0], 1'b0);
        $display("test immediate latch done");
    endtask
    task t_def;
        pwr(RST_LATCH_DEFERRED, ACT_HIGH_BAL);
        setv(105, 5);
        u.press(0);
        cyc(3);
        chk("pending0", pend[0], 1'b1);
        chk("sp_out0", out[0], 1'b1);
        setv(90, 5);
        chk("sp_out0", out[0], 1'b0);
        chk("pending0", pend[0], 1'b0);
        $display("test deferred latch done");
    endtask
    task t_dly;
        ond = '{10'h003, 10'h003};
        pwr(RST_AUTO, ACT_HIGH_BAL);
        setv(105, 15);
        chk("sp_out0", out[0], 1'b0);
        cyc(25);
        chk("sp_out0", out[0], 1'b1);
        chk("colour", col, 1'b1);
        $display("test on delay done");
    endtask
    task t_disp;
        pwr(RST_AUTO, ACT_HIGH_BAL);
        setv(105, 5);
        u.press(2);
        cyc(3);
        chk("sp_out0", out[0], 1'b1);
        rwd = 2'b01;
        u.press(2);
        cyc(3);
        chk("sp_out0", out[0], 1'b0);
        $display("test display reset done");
    endtask
    task t_stby;
        sby = 2'b01;
        pv = 18'h00069;
        pwr(RST_AUTO, ACT_HIGH_BAL);
        cyc(5);
        chk("sp_out0", out[0], 1'b0);
        setv(90, 5);
        setv(105, 5);
        chk("sp_out0", out[0], 1'b1);
        $display("test standby done");
    endtask
    task t_rest;
        prl = 2'b01;
        pv = 18'h00069;
        pwr(RST_LATCH_DEFERRED, ACT_HIGH_BAL);
        chk("sp_out0", out[0], 1'b1);
        u.press(0);
        cyc(3);
        chk("pending0", pend[0], 1'b1);
        pwr(RST_LATCH_DEFERRED, ACT_HIGH_BAL);
        chk("pending0", pend[0], 1'b0);
        pv = 18'h0005a;
        pwr(RST_LATCH_IMMEDIATE, ACT_HIGH_BAL);
        cyc(3);
        chk("sp_out0", out[0], 1'b0);
        prl = 2'b00;
        pv = 18'h00000;
        $display("test restore done");
    endtask
    task t_sp2;
        sp2 = 1'b1;
        pwr(RST_AUTO, ACT_HIGH_BAL);
        setv(105, 5);
        chk("sp_out", out, 2'b11);
        sp2 = 1'b0;
        cyc(3);
        chk("sp_out", out, 2'b01);
        $display("test second setpoint done");
    endtask
    task t_off;
        ofd = '{13'h0003, 13'h0003};
        pwr(RST_AUTO, ACT_HIGH_BAL);
        setv(105, 5);
        setv(94, 15);
        setv(100, 5);
        setv(94, 15);
        chk("sp_out0", out[0], 1'b1);
        cyc(25);
        chk("sp_out0", out[0], 1'b0);
        $display("test off delay done");
    endtask

    always @(posedge clk) begin
        cc++;
        if (cc == 5000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        t_auto;
        t_unbal;
        t_imm;
        t_def;
        t_disp;
        t_stby;
        t_rest;
        t_sp2;
        t_off;
        t_dly;
        stop_test;
    end
endmodule // setpoint_output_control_tb_top
